// file: src/mpcb_top.sv
// Purpose: Pin-level control of a PLL multiphase clock buffer, digital model
// Assumes: Reference and feedback pins are asynchronous; straps are static
// Notes: The loop is modelled as a divided clock aligned to reference edges
`timescale 1ns/1ps
// How it works
// - Feedback pair B when select high, else A
// - Phase counter aligns to selected reference edges
// - Reference pair B when select high, else A
// - Feedback bank disabled per output mode when high
// - Each bank disable gates its own four outputs
// - Output mode: high Z, hold-off, or test
// - Bank 3 invert: complement pairs, all, or none
// - Lock high when locked, low while acquiring
// - Three-level codes decode low, mid, high
// - Feedback bank phase and divide from own selects
// - Each bank uses own phase and divide selects
// - Divide pair encodes ratios one to six
// - Offsets are whole multiples of phase unit
// - Per-bank offset tables including copy codes
module mpcb_top (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic feedback_pair_select, // Feedback source select
  input wire logic feedback_in_pair_a, // Feedback pair A true pin
  input wire logic feedback_in_pair_b, // Feedback pair B true pin
  input wire logic reference_pair_select, // Reference source select
  input wire logic reference_in_pair_a, // Reference pair A true pin
  input wire logic reference_in_pair_b, // Reference pair B true pin
  input wire logic [1:0] frequency_range_select, // Three-level code
  input wire logic [1:0] output_mode_select, // Three-level code
  input wire logic [1:0] bank3_invert_select, // Three-level code
  input wire logic [1:0] feedback_phase_select, // Three-level code
  input wire logic [3:0] feedback_divide_select, // [3:2] bit1, [1:0] bit0
  input wire logic feedback_bank_disable, // High disables feedback bank
  input wire logic [15:0] bank_phase_select, // Per bank {f1,f0}, bank1 lowest
  input wire logic [15:0] bank_divide_select, // Per bank {ds1,ds0}, bank1 lowest
  input wire logic [3:0] bank_disable, // High disables bank, bit0 = bank1
  output logic [15:0] bank_outputs, // Bank n at [4n-1:4n-4], {qb1,qb0,qa1,qa0}
  output logic [15:0] bank_output_enable, // High while driving
  output logic [1:0] feedback_bank_outputs, // Feedback bank clocks
  output logic [1:0] feedback_output_enable, // High while driving
  output logic lock, // Loop locked
  output logic test_mode, // Factory test mode active
  output logic [1:0] range_code // Frequency range strap as seen
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic mpcb_pkg::mpcb_lvl_t lvl(input logic [1:0] c);
    lvl = mpcb_pkg::mpcb_lvl_t'(c);
  endfunction : lvl

  // Ratio from a divider pair; illegal codes fall back to divide by one
  function automatic logic [2:0] div_of(input logic [1:0] d1, input logic [1:0] d0);
    logic [2:0] r;
    r = 3'h1;
    if (lvl(d1) == mpcb_pkg::MPCB_LOW && lvl(d0) != mpcb_pkg::MPCB_BAD) begin
      r = 3'h1 + {1'b0, d0};
    end else if (lvl(d1) == mpcb_pkg::MPCB_MID && lvl(d0) != mpcb_pkg::MPCB_BAD) begin
      r = 3'h4 + {1'b0, d0};
    end
    div_of = r;
  endfunction : div_of

  // Offset in units, biased by OFS_CENTER; bank 3 and 4 copy codes
  function automatic logic [3:0] ofs_of(input int bank, input logic [1:0] f1,
                                        input logic [1:0] f0, input logic [3:0] cp1,
                                        input logic [3:0] cp2);
    logic [3:0] i;
    logic [3:0] o;
    i = 4'(f1) * 4'h3 + 4'(f0);
    o = mpcb_pkg::OFS_CENTER;
    if (f1 != 2'h3 && f0 != 2'h3) begin
      if (bank < 2) begin
        o = i + 4'h4;
      end else begin
        unique case (i)
          4'h3: o = cp1;
          4'h5: o = cp2;
          4'h4: o = mpcb_pkg::OFS_CENTER;
          default: o = i;
        endcase
        if (i < 4'h3) begin
          o = 4'h0 + i; // -8,-7,-6 as 0..2 on a 16-unit range
        end else if (i > 4'h5) begin
          o = i + 4'h8; // +6,+7,+8 as 14,15 and 16 wrapped to 0
        end
      end
    end
    ofs_of = o;
  endfunction : ofs_of

  // ----------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_ok;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_r[1];

  logic [3:0] clk_meta_r;
  logic [3:0] clk_sync_r;
  logic ref_prev_r;
  logic fb_prev_r;
  logic ref_sel;
  logic fb_sel;
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      clk_meta_r <= 4'h0;
      clk_sync_r <= 4'h0;
      ref_prev_r <= 1'b0;
      fb_prev_r <= 1'b0;
    end else begin
      clk_meta_r <= {feedback_in_pair_b, feedback_in_pair_a,
                     reference_in_pair_b, reference_in_pair_a};
      clk_sync_r <= clk_meta_r;
      ref_prev_r <= ref_sel;
      fb_prev_r <= fb_sel;
    end
  end
  // Selects come from the synchronised strap copy, never the raw pins
  assign ref_sel = cfg_r[54] ? clk_sync_r[1] : clk_sync_r[0];
  assign fb_sel = cfg_r[55] ? clk_sync_r[3] : clk_sync_r[2];

  // ----------------------------------------
  // Static select sampling and change detect
  // ----------------------------------------
  logic [55:0] cfg_meta_r;
  logic [55:0] cfg_r;
  logic [55:0] cfg_prev_r;
  logic cfg_changed;
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      cfg_meta_r <= '0;
      cfg_r <= '0;
      cfg_prev_r <= '0;
    end else begin
      cfg_meta_r <= {feedback_pair_select, reference_pair_select, feedback_bank_disable,
                     bank_disable, bank_divide_select, bank_phase_select,
                     feedback_divide_select, feedback_phase_select, bank3_invert_select,
                     output_mode_select, frequency_range_select, 5'h00};
      cfg_r <= cfg_meta_r;
      cfg_prev_r <= cfg_r;
    end
  end
  assign cfg_changed = (cfg_r != cfg_prev_r);

  logic [1:0] fs_s;
  logic [1:0] om_s;
  logic [1:0] inv_s;
  logic [1:0] fbf_s;
  logic [3:0] fbd_s;
  logic feedback_bank_disable_s;
  logic [15:0] bph_s;
  logic [15:0] bdv_s;
  logic [3:0] bdis_s;
  assign fs_s = cfg_r[6:5];
  assign om_s = cfg_r[8:7];
  assign inv_s = cfg_r[10:9];
  assign fbf_s = cfg_r[12:11];
  assign fbd_s = cfg_r[16:13];
  assign bph_s = cfg_r[32:17];
  assign bdv_s = cfg_r[48:33];
  assign bdis_s = cfg_r[52:49];
  assign feedback_bank_disable_s = cfg_r[53];

  // ----------------------------------------
  // Loop model: unit counter aligned to reference
  // ----------------------------------------
  logic [3:0] unit_r;
  logic [2:0] lock_cnt_r;
  logic phase_ok;
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      unit_r <= 4'h0;
    end else if (ref_sel && !ref_prev_r) begin
      unit_r <= 4'h1;
    end else begin
      unit_r <= unit_r + 4'h1;
    end
  end
  assign phase_ok = !(fb_sel && !fb_prev_r) || (unit_r <= 4'h2) || (unit_r >= 4'hE);

  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      lock_cnt_r <= 3'h0;
      lock <= 1'b0;
    end else if (cfg_changed || !phase_ok) begin
      lock_cnt_r <= 3'h0;
      lock <= 1'b0;
    end else if (ref_sel && !ref_prev_r) begin
      if (lock_cnt_r == 3'(mpcb_pkg::LOCK_EDGES)) begin
        lock <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Per-bank divided, offset clocks
  // ----------------------------------------
  logic [3:0] sub_r;
  logic [5:0] ref_cnt_r;
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      sub_r <= 4'h0;
      ref_cnt_r <= 6'h00;
    end else if (ref_sel && !ref_prev_r) begin
      sub_r <= 4'h0;
      ref_cnt_r <= (ref_cnt_r == mpcb_pkg::REF_WRAP) ? 6'h00 : ref_cnt_r + 6'h01;
    end else begin
      sub_r <= sub_r + 4'h1;
    end
  end

  logic [4:0] bank_clk;
  logic [4:0] bank_en;
  logic [3:0] ofs [5];
  always_comb begin
    ofs[0] = ofs_of(0, bph_s[3:2], bph_s[1:0], 4'h0, 4'h0);
    ofs[1] = ofs_of(1, bph_s[7:6], bph_s[5:4], 4'h0, 4'h0);
    ofs[2] = ofs_of(2, bph_s[11:10], bph_s[9:8], ofs[0], ofs[1]);
    ofs[3] = ofs_of(3, bph_s[15:14], bph_s[13:12], ofs[0], ofs[1]);
    ofs[4] = (lvl(fbf_s) == mpcb_pkg::MPCB_LOW) ? 4'h4 :
             (lvl(fbf_s) == mpcb_pkg::MPCB_HIGH) ? 4'hC : mpcb_pkg::OFS_CENTER;
  end
  always_comb begin
    for (int b = 0; b < 5; b++) begin
      logic [2:0] d;
      logic [9:0] t;
      d = (b < 4) ? div_of(bdv_s[4*b+3 -: 2], bdv_s[4*b+1 -: 2])
                  : div_of(fbd_s[3:2], fbd_s[1:0]);
      // Larger offset delays the bank
      t = {ref_cnt_r, sub_r} + mpcb_pkg::LEAD_UNITS - {6'h00, ofs[b]};
      bank_clk[b] = ((t % ({7'h00, d} * 10'h010)) <
                     ({7'h00, d} * {2'h0, mpcb_pkg::HALF_UNITS}));
      bank_en[b] = (b < 4) ? !bdis_s[b] : !feedback_bank_disable_s;
    end
  end

  // ----------------------------------------
  // Output staging
  // ----------------------------------------
  logic hiz_mode;
  assign hiz_mode = (lvl(om_s) == mpcb_pkg::MPCB_HIGH);
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      bank_outputs <= 16'h0000;
      bank_output_enable <= 16'h0000;
      feedback_bank_outputs <= 2'h0;
      feedback_output_enable <= 2'h0;
      test_mode <= 1'b0;
      range_code <= 2'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        logic c;
        c = bank_en[b] && bank_clk[b];
        bank_outputs[4*b +: 4] <= {4{c}};
        if (b == 2) begin
          unique case (lvl(inv_s))
            mpcb_pkg::MPCB_LOW: bank_outputs[4*b +: 4] <= {!c, c, !c, c};
            mpcb_pkg::MPCB_HIGH: bank_outputs[4*b +: 4] <= {4{!c}};
            default: bank_outputs[4*b +: 4] <= {4{c}};
          endcase
          if (!bank_en[b]) begin
            bank_outputs[4*b +: 4] <= 4'h0;
          end
        end
        bank_output_enable[4*b +: 4] <= {4{bank_en[b] || !hiz_mode}};
      end
      feedback_bank_outputs <= {2{bank_en[4] && bank_clk[4]}};
      feedback_output_enable <= {2{bank_en[4] || !hiz_mode}};
      test_mode <= (lvl(om_s) == mpcb_pkg::MPCB_MID);
      range_code <= fs_s;
    end
  end
endmodule : mpcb_top

// file: src/mpcb_pkg.sv
// Purpose: Shared constants for the multiphase clock bank control block
// Assumes: Three-level pins arrive pre-encoded as 2-bit codes
// Notes: Phase unit is one fast tick; divide counts are in phase-unit ticks
package mpcb_pkg;
  // ----------------------------------------
  // Three-level select encoding
  // ----------------------------------------
  typedef enum logic [1:0] {
    MPCB_LOW,
    MPCB_MID,
    MPCB_HIGH,
    MPCB_BAD
  } mpcb_lvl_t;
  // ----------------------------------------
  // Loop timing
  // ----------------------------------------
  localparam int UNIT_PER_PERIOD = 16;
  localparam logic [7:0] HALF_UNITS = 8'h08;
  localparam int LOCK_EDGES = 4;
  localparam logic [3:0] OFS_CENTER = 4'h8;
  localparam logic [2:0] DIV_MAX = 3'h6;
  // Sixty reference periods hold a whole number of periods for every divide
  localparam logic [5:0] REF_WRAP = 6'h3B;
  // Lead that hides the output and sync pipeline, so feedback lands on reference
  localparam logic [9:0] LEAD_UNITS = 10'h01C;
  // Output counts: four banks of four outputs, two feedback outputs
  localparam int BANKS = 4;
  localparam int OUTS_PER_BANK = 4;
  localparam int FB_OUTS = 2;
endpackage : mpcb_pkg

// file: tb/mpcb_top_sva.sv
// Purpose: Port assertions for mpcb_top
// Assumes: Straps held 4 cycles before judging
// Notes: Outputs follow straps 3 cycles late
`timescale 1ns/1ps
module mpcb_top_sva (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic feedback_pair_select, // Fb source
  input wire logic [1:0] frequency_range_select, // Range
  input wire logic [1:0] output_mode_select, // Mode
  input wire logic [1:0] bank3_invert_select, // Invert
  input wire logic feedback_bank_disable, // Fb off
  input wire logic [15:0] bank_divide_select, // Divides
  input wire logic [3:0] bank_disable, // Bank off
  input wire logic [15:0] bank_outputs, // Clocks
  input wire logic [15:0] bank_output_enable, // Drives
  input wire logic [1:0] feedback_output_enable, // Fb drives
  input wire logic lock, // Lock
  input wire logic test_mode, // Test
  input wire logic [1:0] range_code // Echo
);
  // ----
  // Guard past the reset pipeline
  // ----
  logic [3:0] up_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) up_r <= 4'h0;
    else if (up_r != 4'hF) up_r <= up_r + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    up_r == 4'hF && $stable(output_mode_select) && $stable(bank_disable) &&
    $stable(bank3_invert_select) && $stable(feedback_bank_disable);
  endsequence
  test_flag_a: assert property (
    s_quiet [*4] |-> test_mode == (output_mode_select == 2'h1)) else $error("test flag");
  hold_low_a: assert property (
    s_quiet [*4] ##0 (bank_disable[1] && output_mode_select == 2'h0)
    |-> bank_outputs[7:4] == 4'h0) else $error("hold-off level");
  bank_drive_a: assert property (
    s_quiet [*4] ##0 output_mode_select != 2'h1 |-> bank_output_enable[7:4] ==
    {4{!(bank_disable[1] && output_mode_select == 2'h2)}}) else $error("bank enable");
  fb_drive_a: assert property (
    s_quiet [*4] ##0 output_mode_select != 2'h1 |-> feedback_output_enable ==
    {2{!(feedback_bank_disable && output_mode_select == 2'h2)}}) else $error("fb enable");
  inv_pair_a: assert property (
    s_quiet [*4] ##0 (bank3_invert_select == 2'h0 && output_mode_select != 2'h1 &&
    !bank_disable[2]) |-> bank_outputs[8] != bank_outputs[9] &&
    bank_outputs[10] != bank_outputs[11]) else $error("pair not complementary");
  inv_same_a: assert property (
    s_quiet [*4] ##0 (bank3_invert_select != 2'h0 && output_mode_select != 2'h1)
    |-> bank_outputs[11:8] inside {4'h0, 4'hF}) else $error("bank 3 split");
  range_echo_a: assert property (
    (up_r == 4'hF && $stable(frequency_range_select)) [*4]
    |-> range_code == frequency_range_select) else $error("range echo");
  div_unlock_a: assert property (
    up_r == 4'hF && $changed(bank_divide_select) |-> ##[1:6] !lock) else $error("lock kept");
  feedback_pair_select_unlock_a: assert property (
    up_r == 4'hF && $changed(feedback_pair_select) |-> ##[1:24] !lock) else $error("fb lock");
endmodule : mpcb_top_sva

// file: tb/mpcb_board.sv
// Purpose: Board model: reference sources, feedback routing
// Assumes: Single-ended sources on the true pins only
// Notes: Route B returns feedback eight units late
`timescale 1ns/1ps
module mpcb_board (
  input wire logic clk_sys, // Sampling clock
  input wire logic [1:0] fb_loop, // Feedback bank clocks
  output logic ref_a, // Source A
  output logic ref_b, // Source B
  output logic fb_a, // Direct return
  output logic fb_b // Skewed return
);
  logic [7:0] dly_r;
  initial begin
    ref_a = 1'b0;
    #3;
    forever #80 ref_a = !ref_a;
  end
  assign ref_b = !ref_a;
  assign fb_a = fb_loop[0];
  always_ff @(posedge clk_sys) dly_r <= {dly_r[6:0], fb_loop[1]};
  assign fb_b = dly_r[7];
endmodule : mpcb_board

// file: tb/tb_top.sv
// Purpose: Directed bench for mpcb_top
// Assumes: Loop closed through feedback output 0
// Notes: Straps and reset move on falling edges
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic feedback_pair_select = 1'b0;
  logic reference_pair_select = 1'b0;
  logic [1:0] frequency_range_select = 2'h1;
  logic [1:0] output_mode_select = 2'h0;
  logic [1:0] bank3_invert_select = 2'h1;
  logic [1:0] feedback_phase_select = 2'h1;
  logic [3:0] feedback_divide_select = 4'h0;
  logic feedback_bank_disable = 1'b0;
  logic [15:0] bank_phase_select = 16'h5555;
  logic [15:0] bank_divide_select = 16'h0000;
  logic [3:0] bank_disable = 4'h0;
  logic [15:0] bank_outputs, bank_output_enable;
  logic [1:0] feedback_bank_outputs, feedback_output_enable, range_code;
  logic lock, test_mode, ref_a, ref_b, fb_a, fb_b;
  logic [3:0] v;
  logic [3:0] dsel [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
  int errors = 0;
  int tests_run = 0;
  int gap;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error %0t: got %0h want %0h", $time, g, e); end end
  initial begin
    forever #5 clk_sys = !clk_sys;
  end
  mpcb_top u_mpcb_top (
    .clk_sys, .rst_n, .feedback_pair_select, .feedback_in_pair_a(fb_a),
    .feedback_in_pair_b(fb_b), .reference_pair_select, .reference_in_pair_a(ref_a),
    .reference_in_pair_b(ref_b), .frequency_range_select, .output_mode_select,
    .bank3_invert_select, .feedback_phase_select, .feedback_divide_select,
    .feedback_bank_disable, .bank_phase_select, .bank_divide_select, .bank_disable,
    .bank_outputs, .bank_output_enable, .feedback_bank_outputs, .feedback_output_enable,
    .lock, .test_mode, .range_code);
  mpcb_board u_mpcb_board (.clk_sys, .fb_loop(feedback_bank_outputs), .ref_a, .ref_b,
    .fb_a, .fb_b);
  task automatic test_done;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wait_lock(input logic e);
    int k;
    k = 0;
    while (lock !== e && k < 600) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK(lock, e)
    if (k == 600) test_done();
  endtask : wait_lock
  task automatic settle;
    repeat (40) @(negedge clk_sys);
    wait_lock(1'b1);
  endtask : settle
  // Cycles until the next rising edge of one output
  task automatic rise(input int b, output int n);
    logic lo;
    lo = 1'b0;
    n = 0;
    while (!(lo && bank_outputs[b] === 1'b1)) begin
      lo = lo || (bank_outputs[b] === 1'b0);
      @(negedge clk_sys);
      n++;
      if (n > 200) begin
        `CHK(n, 0)
        test_done();
      end
    end
  endtask : rise
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    wait_lock(1'b1);
    `CHK(range_code, 2'h1)
    for (int i = 0; i < 6; i++) begin
      bank_divide_select[3:0] = dsel[i];
      settle();
      rise(0, gap);
      rise(0, gap);
      `CHK(gap, 16 * (i + 1))
      rise(4, gap);
      rise(4, gap);
      `CHK(gap, 16)
    end
    bank_divide_select = 16'h0000;
    bank_phase_select[7:4] = 4'hA;
    settle();
    rise(0, gap);
    rise(4, gap);
    `CHK(gap, 4)
    bank_phase_select = 16'h6505;
    settle();
    rise(0, gap);
    rise(12, gap);
    `CHK(gap, 12)
    bank_phase_select = 16'h5555;
    bank_disable = 4'h2;
    settle();
    `CHK(bank_outputs[7:4], 4'h0)
    `CHK(bank_output_enable, 16'hFFFF)
    output_mode_select = 2'h2;
    repeat (8) @(negedge clk_sys);
    `CHK(bank_output_enable, 16'hFF0F)
    feedback_bank_disable = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK(feedback_output_enable, 2'h0)
    output_mode_select = 2'h1;
    repeat (8) @(negedge clk_sys);
    `CHK(test_mode, 1'b1)
    output_mode_select = 2'h0;
    feedback_bank_disable = 1'b0;
    bank_disable = 4'h0;
    for (int m = 0; m < 3; m++) begin
      bank3_invert_select = m[1:0];
      settle();
      repeat (16) begin
        @(negedge clk_sys);
        v = {4{bank_outputs[12]}};
        `CHK(bank_outputs[11:8], m == 0 ? v ^ 4'hA : (m == 2 ? ~v : v))
      end
    end
    bank3_invert_select = 2'h1;
    feedback_pair_select = 1'b1;
    wait_lock(1'b0);
    repeat (100) @(negedge clk_sys);
    `CHK(lock, 1'b0)
    feedback_pair_select = 1'b0;
    settle();
    reference_pair_select = 1'b1;
    wait_lock(1'b0);
    settle();
    test_done();
  end
endmodule : tb_top
bind mpcb_top mpcb_top_sva u_mpcb_top_sva (.clk_sys, .rst_n, .feedback_pair_select,
  .frequency_range_select, .output_mode_select, .bank3_invert_select,
  .feedback_bank_disable, .bank_divide_select, .bank_disable, .bank_outputs,
  .bank_output_enable, .feedback_output_enable, .lock, .test_mode, .range_code);
